// ===== core/ifeb_apb_slave.sv
// file: apb slave front end with zero wait state answer
`timescale 1ns/1ps
module ifeb_apb_slave
    import ifeb_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire ifeb_apb_req_t req,
    input  wire logic [31:0]   rd_word,
    input  wire logic          rd_hit,
    output logic               pready,
    output logic               pslverr,
    output logic [31:0]        prdata,
    output logic               wr_stb,
    output logic               rd_stb
);

    // access phase strobes; answer is always in the first access cycle
    assign pready  = 1'b1;
    assign wr_stb  = req.sel & req.enable & req.write;
    assign rd_stb  = req.sel & req.enable & ~req.write;
    // unmapped reads and writes answer with an error
    assign pslverr = req.sel & req.enable & ~rd_hit;
    // read data is the combinational decode; it is valid in the access cycle
    assign prdata  = rd_stb ? rd_word : 32'h0000_0000;

endmodule : ifeb_apb_slave

// ===== core/ifeb_bank.sv
// file: interrupt flag and enable bank with apb access and service hook
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ifeb_bank
    import ifeb_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic               pslverr,
    output logic [31:0]        prdata,
    input  wire ifeb_events_t  events,
    input  wire logic          irq_service,
    output logic [IFEB_NSRC-1:0] src_pending,
    output logic               core_irq_req,
    output logic               irq
);

    ifeb_apb_req_t         req;
    logic                  wr_stb;
    logic                  rd_hit;
    logic [31:0]           rd_word;
    logic [7:0]            ctl [IFEB_NREG];
    logic [7:0]            ctl_set [IFEB_NREG];
    logic [7:0]            ctl_clr [IFEB_NREG];
    logic [IFEB_NREG-1:0]  ctl_wr;
    logic [IFEB_NEVT-1:0]  evt_status;
    logic [IFEB_NEVT-1:0]  evt_mask;
    logic [IFEB_NEVT-1:0]  next_evt_status;
    logic [IFEB_NEVT-1:0]  next_evt_mask;
    logic                  req_d;
    logic                  next_req_d;
    logic                  svc_d;
    logic                  next_svc_d;

    // decode a byte address into a control register index
    function automatic int ctl_index(input logic [11:0] a);
        int i;
        i = -1;
        unique case (a)
            IFEB_OFS_CTL0: i = 0;
            IFEB_OFS_CTL1: i = 1;
            IFEB_OFS_CTL2: i = 2;
            IFEB_OFS_CTL3: i = 3;
            IFEB_OFS_CTM:  i = 4;
            default:       i = -1;
        endcase
        return i;
    endfunction : ctl_index

    // implemented bits of register k
    function automatic logic [7:0] impl_of(input int k);
        logic [7:0] m;
        m = IFEB_IMPL_FULL;
        if (k == 0)
            m = IFEB_IMPL_CTL0;
        else if (k == 4)
            m = IFEB_IMPL_CTM;
        return m;
    endfunction : impl_of

    assign req.sel    = psel;
    assign req.enable = penable;
    assign req.write  = pwrite;
    assign req.addr   = paddr;
    assign req.wdata  = pwdata;

    ifeb_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (req),
        .rd_word (rd_word),
        .rd_hit  (rd_hit),
        .pready  (pready),
        .pslverr (pslverr),
        .prdata  (prdata),
        .wr_stb  (wr_stb),
        .rd_stb  ()
    );

    // hardware sets from raw event pulses; flag fields sit in upper nibble
    always_comb
    begin
        for (int k = 0; k < IFEB_NREG; k++)
        begin
            ctl_set[k] = 8'h00;
            ctl_clr[k] = 8'h00;
        end
        // pins 2..0 flags, bits 6..4; pin 0 enable lives at bit 1
        ctl_set[0][6:IFEB_BIT_PIN0_FLAG] = events.ctl0;
        // serial port bit 7, pins 5..3 bits 6..4
        ctl_set[1][7:IFEB_FLAG_LSB]      = events.ctl1;
        // converter bit 7, groups bits 6..4
        ctl_set[2][7:IFEB_FLAG_LSB]      = events.ctl2;
        // serial if, eeprom, time bases
        ctl_set[3][7:IFEB_FLAG_LSB]      = events.ctl3;
        // comparator A bit 5, comparator P bit 4
        ctl_set[4][5:IFEB_FLAG_LSB]      = events.compact_timer;
        // servicing drops the global enable to block nesting
        ctl_clr[0][IFEB_BIT_GIE]         = irq_service;
    end

    // one flag register per documented control register
    genvar g;
    generate
        for (g = 0; g < IFEB_NREG; g++)
        begin : g_ctl
            assign ctl_wr[g] = wr_stb && (ctl_index(paddr) == g);
            // rw bits, zero at reset, unimplemented masked
            ifeb_flag_reg #(
                .IMPL (impl_of(g))
            ) u_reg (
                .pclk     (pclk),
                .presetn  (presetn),
                .wr       (ctl_wr[g]),
                .wdata    (pwdata[7:0]),
                .set_bits (ctl_set[g]),
                .clr_bits (ctl_clr[g]),
                .value    (ctl[g])
            );
        end
    endgenerate

    // pending = flag and enable; flags latch regardless of enable
    always_comb
    begin
        src_pending[2:0]   = ctl[0][6:4] & ctl[0][3:1];
        src_pending[6:3]   = ctl[1][7:4] & ctl[1][3:0];
        src_pending[10:7]  = ctl[2][7:4] & ctl[2][3:0];
        src_pending[14:11] = ctl[3][7:4] & ctl[3][3:0];
        src_pending[16:15] = ctl[4][5:4] & ctl[4][1:0];
        src_pending[19:17] = 3'b000;
    end

    // global enable gates every request to the core
    assign core_irq_req = ctl[0][IFEB_BIT_GIE] & (|src_pending);

    // sticky summary events: set wins over write-one-to-clear
    always_comb
    begin
        next_req_d      = core_irq_req;
        next_svc_d      = irq_service;
        next_evt_status = evt_status;
        next_evt_mask   = evt_mask;
        if (wr_stb && paddr == IFEB_OFS_STATUS)
            next_evt_status = evt_status & ~pwdata[IFEB_NEVT-1:0];
        if (wr_stb && paddr == IFEB_OFS_MASK)
            next_evt_mask = pwdata[IFEB_NEVT-1:0];
        if (irq_service && !svc_d)
            next_evt_status[IFEB_EVT_SERVICE] = 1'b1;
        if (core_irq_req && !req_d)
            next_evt_status[IFEB_EVT_REQUEST] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_status <= '0;
            evt_mask   <= '0;
            req_d      <= 1'b0;
            svc_d      <= 1'b0;
        end
        else
        begin
            evt_status <= next_evt_status;
            evt_mask   <= next_evt_mask;
            req_d      <= next_req_d;
            svc_d      <= next_svc_d;
        end
    end

    assign irq = |(evt_status & evt_mask);

    // read mux; unmapped addresses flag an error through the slave
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (ctl_index(paddr) >= 0)
            rd_word[7:0] = ctl[ctl_index(paddr)];
        else if (paddr == IFEB_OFS_STATUS)
            rd_word[IFEB_NEVT-1:0] = evt_status;
        else if (paddr == IFEB_OFS_MASK)
            rd_word[IFEB_NEVT-1:0] = evt_mask;
        else
            rd_hit = 1'b0;
    end

endmodule : ifeb_bank

// ===== core/ifeb_flag_reg.sv
// file: one eight bit flag and enable control register
`timescale 1ns/1ps
module ifeb_flag_reg
    import ifeb_pkg::*;
#(
    parameter logic [7:0] IMPL = IFEB_IMPL_FULL
)(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] set_bits,
    input  wire logic [7:0] clr_bits,
    output logic [7:0]      value
);

    logic [7:0] next_value;

    // software write first, then hardware clear, then hardware set wins
    always_comb
    begin
        next_value = value;
        if (wr)
            next_value = wdata;
        next_value = (next_value & ~clr_bits) | set_bits;
        next_value = next_value & IMPL;
    end

    // registers only; absent bits never hold a one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            value <= IFEB_RST_CTL;
        else
            value <= next_value;
    end

endmodule : ifeb_flag_reg

// ===== inc/ifeb_pkg.sv
// package: register map, field positions and carriers for the flag bank
package ifeb_pkg;

    // byte addresses of the control, status and mask registers on the register bus
    localparam logic [11:0] IFEB_OFS_CTL0   = 12'h000;
    localparam logic [11:0] IFEB_OFS_CTL1   = 12'h004;
    localparam logic [11:0] IFEB_OFS_CTL2   = 12'h008;
    localparam logic [11:0] IFEB_OFS_CTL3   = 12'h00C;
    localparam logic [11:0] IFEB_OFS_CTM    = 12'h010;
    localparam logic [11:0] IFEB_OFS_STATUS = 12'h014;
    localparam logic [11:0] IFEB_OFS_MASK   = 12'h018;
    localparam int          IFEB_NREG       = 5;
    localparam int          IFEB_NSRC       = 20;

    // reset value of every control register
    localparam logic [7:0] IFEB_RST_CTL = 8'h00;

    // implemented bits of each control register
    localparam logic [7:0] IFEB_IMPL_CTL0 = 8'h7F;
    localparam logic [7:0] IFEB_IMPL_FULL = 8'hFF;
    localparam logic [7:0] IFEB_IMPL_CTM  = 8'h33;

    // field positions
    localparam int IFEB_BIT_GIE       = 0;
    localparam int IFEB_BIT_PIN0_EN   = 1;
    localparam int IFEB_BIT_PIN0_FLAG = 4;
    localparam int IFEB_FLAG_LSB      = 4;
    localparam int IFEB_EN_LSB        = 0;

    // aggregator status/mask bit positions
    localparam int IFEB_EVT_SERVICE = 0;
    localparam int IFEB_EVT_REQUEST = 1;
    localparam int IFEB_NEVT        = 2;

    // apb request carrier
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ifeb_apb_req_t;

    // raw event pulses, one per source, grouped by register
    typedef struct packed {
        logic [1:0] compact_timer;
        logic [3:0] ctl3;
        logic [3:0] ctl2;
        logic [3:0] ctl1;
        logic [2:0] ctl0;
    } ifeb_events_t;

endpackage : ifeb_pkg

// ===== tb/ifeb_bank_asserts.sv
// checker: bus answer, pending flags and service of the flag bank
`timescale 1ns/1ps
module ifeb_bank_asserts
    import ifeb_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [31:0]          prdata,
    input wire ifeb_events_t         events,
    input wire logic                 irq_service,
    input wire logic [IFEB_NSRC-1:0] src_pending,
    input wire logic                 core_irq_req,
    input wire logic                 irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    logic wr;
    // access phase and write strobe as the bank sees them
    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    property p_rdy;
        acc |-> pready;
    endproperty
    property p_hi_zero;
        src_pending[19:17] == 3'h0;
    endproperty
    property p_svc;
        irq_service && !(wr && paddr == IFEB_OFS_CTL0 && pwdata[0])
            |=> !core_irq_req;
    endproperty
    // a pending source only drops through a software write
    property p_keep;
        !wr |=> ($past(src_pending) & ~src_pending) == 20'h0;
    endproperty
    property p_new;
        !wr && events == '0 |=> (src_pending & ~$past(src_pending)) == 20'h0;
    endproperty
    property p_err;
        acc && pslverr |-> prdata == 32'h0;
    endproperty
    property p_ctm;
        acc && !pwrite && paddr == IFEB_OFS_CTM |-> (prdata & ~32'h33) == 32'h0;
    endproperty
    property p_ctl0;
        acc && !pwrite && paddr == IFEB_OFS_CTL0 |-> prdata[31:7] == 25'h0;
    endproperty
    // dropping the global enable by software masks every request
    property p_gie;
        wr && paddr == IFEB_OFS_CTL0 && !pwdata[IFEB_BIT_GIE]
            |=> !core_irq_req;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready in access");
    a_hi_zero: assert property (p_hi_zero) else $error("spare pend");
    a_svc: assert property (p_svc) else $error("service kept req");
    a_keep: assert property (p_keep) else $error("pending lost");
    a_new: assert property (p_new) else $error("pending from none");
    a_err: assert property (p_err) else $error("error read data");
    a_ctm: assert property (p_ctm) else $error("timer spare bits");
    a_ctl0: assert property (p_ctl0) else $error("ctl0 spare bits");
    a_gie: assert property (p_gie) else $error("req w/o global");
    c_svc: cover property (irq_service ##1 !core_irq_req);
    c_err: cover property (acc && pslverr);
    c_irq: cover property ($rose(irq));
endmodule : ifeb_bank_asserts

// ===== tb/ifeb_src_model.sv
// far-end model: event sources and the core's service acknowledge
`timescale 1ns/1ps
module ifeb_src_model
    import ifeb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [16:0] fire_evt,
    input  wire logic        fire_svc,
    output ifeb_events_t     events,
    output logic             irq_service
);
    // one-cycle pulses, the shortest event the bank must catch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            events      <= '0;
            irq_service <= 1'b0;
        end
        else
        begin
            events      <= ifeb_events_t'(fire_evt);
            irq_service <= fire_svc;
        end
    end
endmodule : ifeb_src_model

// ===== tb/testbench.sv
// testbench: register access, event flags and service of the flag bank
`timescale 1ns/1ps
module testbench
    import ifeb_pkg::*;
;
    logic                 pclk, presetn, psel, penable, pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rdat;
    logic                 pready, pslverr, irq_service, core_irq_req, irq;
    ifeb_events_t         events;
    logic [IFEB_NSRC-1:0] src_pending;
    logic [16:0]          fire_evt;
    logic                 fire_svc, rerr;
    int                   err_count = 0;
    int                   num_checks = 0;
    int                   cyc = 0;
    localparam logic [11:0] OFS [5] = '{IFEB_OFS_CTL0, IFEB_OFS_CTL1,
        IFEB_OFS_CTL2, IFEB_OFS_CTL3, IFEB_OFS_CTM};
    localparam logic [7:0] IMPL [5] = '{IFEB_IMPL_CTL0, IFEB_IMPL_FULL,
        IFEB_IMPL_FULL, IFEB_IMPL_FULL, IFEB_IMPL_CTM};
    ifeb_bank i_ifeb_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .events(events),
        .irq_service(irq_service), .src_pending(src_pending),
        .core_irq_req(core_irq_req), .irq(irq));
    ifeb_src_model i_ifeb_src_model (.pclk(pclk), .presetn(presetn),
        .fire_evt(fire_evt), .fire_svc(fire_svc), .events(events),
        .irq_service(irq_service));
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb
    // ends once the pulse has reached the bank's flags
    task automatic fire(input logic [16:0] e, input logic s);
        @(posedge pclk);
        fire_evt <= e;
        fire_svc <= s;
        @(posedge pclk);
        fire_evt <= 17'h0;
        fire_svc <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
    endtask : fire
    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            print_verdict();
        end
    end
    initial
    begin
        int r;
        int b;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {fire_evt, fire_svc, presetn} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            apb(1'b0, OFS[k], 0);
            chk("reset", rdat, 32'h0);
            chk("mapped", {31'h0, rerr}, 32'h0);
            apb(1'b1, OFS[k], 32'hFF);
            apb(1'b0, OFS[k], 0);
            chk("impl", rdat, {24'h0, IMPL[k]});
            apb(1'b1, OFS[k], 0);
        end
        apb(1'b1, IFEB_OFS_STATUS, 32'h3);
        // each source: flag while disabled, pending once enabled
        for (int i = 0; i < 17; i++)
        begin
            r = (i < 3) ? 0 : (i - 3) / 4 + 1;
            b = (i < 3) ? i : (i - 3) % 4;
            fire(17'h1 << i, 1'b0);
            apb(1'b0, OFS[r], 0);
            chk("flag", rdat, 32'h10 << b);
            chk("masked", {12'h0, src_pending}, 32'h0);
            apb(1'b1, OFS[r], (32'h10 << b) | (32'h1 << (b + (r == 0))));
            chk("pending", {12'h0, src_pending}, 32'h1 << i);
            apb(1'b1, OFS[r], 0);
        end
        apb(1'b1, IFEB_OFS_CTL0, 32'h3);
        fire(17'h1, 1'b0);
        chk("core req", {31'h0, core_irq_req}, 32'h1);
        fire(17'h0, 1'b1);
        chk("core req off", {31'h0, core_irq_req}, 32'h0);
        apb(1'b0, IFEB_OFS_CTL0, 0);
        chk("global off", rdat, 32'h12);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, IFEB_OFS_MASK, 32'h3);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b0, IFEB_OFS_MASK, 0);
        chk("mask", rdat, 32'h3);
        apb(1'b0, IFEB_OFS_STATUS, 0);
        chk("status", rdat, 32'h3);
        apb(1'b1, IFEB_OFS_STATUS, 32'h1);
        apb(1'b0, IFEB_OFS_STATUS, 0);
        chk("w1c", rdat, 32'h2);
        apb(1'b1, IFEB_OFS_STATUS, 32'h2);
        chk("irq clr", {31'h0, irq}, 32'h0);
        apb(1'b0, 12'h01C, 0);
        chk("unmapped err", {31'h0, rerr}, 32'h1);
        chk("unmapped data", rdat, 32'h0);
        // reset in mid-run must clear the pending pin 0 flag and enable
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IFEB_OFS_CTL0, 0);
        chk("mid reset", rdat, 32'h0);
        print_verdict();
    end
endmodule : testbench
bind ifeb_bank ifeb_bank_asserts u_ifeb_bank_asserts (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .events(events), .irq_service(irq_service),
    .src_pending(src_pending), .core_irq_req(core_irq_req), .irq(irq));
